// ==== design/imec_regs.vh ====
/*
 header of register offsets, reset values and field positions for the
 interrupt mask and edge-clear unit. assumes a 16-bit register port
 addressed by the printed byte locations.

 // Operation
 // - low enable gates requests 0-15, resets zero
 // - high enable gates requests 16-31, resets zero
 // - low enable bit 0 has no effect
 // - low clear write one clears pending bit
 // - high clear write one clears pending bit
 // - clears ignored for level-triggered requests
 // - clear registers always read all ones
 // - low clear bits 15-1 map, bit0 reserved
 // - high clear bits map requests 31-16
 // - status shows pending regardless of enable
 // - low status bit 0 always reads zero
*/
`ifndef IMEC_REGS_VH
`define IMEC_REGS_VH
`define IMEC_AW              24
`define IMEC_DW              16
`define IMEC_OFF_STAT_LOW    24'h00fe0a
`define IMEC_OFF_STAT_HIGH   24'h00fe0c
`define IMEC_OFF_EN_LOW      24'h00fe0e
`define IMEC_OFF_EN_HIGH     24'h00fe10
`define IMEC_OFF_CLR_LOW     24'h00fe12
`define IMEC_OFF_CLR_HIGH    24'h00fe14
`define IMEC_RST_EN          16'h0000
`define IMEC_RST_STAT        16'h0000
`define IMEC_CLR_READ        16'hffff
`define IMEC_LOW_USED_MASK   16'hfffe
`define IMEC_ZERO16          16'h0000
`define IMEC_NREQ            32
`define IMEC_ZERO32          32'h00000000
`define IMEC_LO_MSB          15
`define IMEC_LO_LSB          0
`define IMEC_HI_MSB          31
`define IMEC_HI_LSB          16
`endif

// ==== design/imec_unit.v ====
/*
 interrupt mask and edge-clear unit: pending status, enable registers,
 edge-clear registers and the masked request output.
 assumes request inputs are synchronous to clock, a per-request edge or
 level select that software leaves alone while requests are live, and a
 register master that never raises wr and rd in the same cycle.
*/
// Strobed register access was decided locally.
`timescale 1ns/1ns
`include "imec_regs.vh"

module imec_unit (
    input  wire                 clock,
    input  wire                 rstn,
    input  wire [`IMEC_AW-1:0]  addr,
    input  wire [`IMEC_DW-1:0]  wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [`IMEC_DW-1:0]  rdata,
    input  wire [31:0]          irq_in,
    input  wire [31:0]          edge_mode,
    output reg  [31:0]          masked_req,
    output reg                  irq_out
);

    // true when the bus address selects the register at offset off
    function addr_hit;
        input [`IMEC_AW-1:0] a;
        input [`IMEC_AW-1:0] off;
        begin
            addr_hit = (a == off);
        end
    endfunction

    // lower half of a request vector: requests 15 down to 0
    function [`IMEC_DW-1:0] lo_half;
        input [`IMEC_NREQ-1:0] v;
        begin
            lo_half = v[`IMEC_LO_MSB:`IMEC_LO_LSB];
        end
    endfunction

    // upper half of a request vector: requests 31 down to 16
    function [`IMEC_DW-1:0] hi_half;
        input [`IMEC_NREQ-1:0] v;
        begin
            hi_half = v[`IMEC_HI_MSB:`IMEC_HI_LSB];
        end
    endfunction

    // rebuild a request vector from its two register halves
    function [`IMEC_NREQ-1:0] join_halves;
        input [`IMEC_DW-1:0] hi;
        input [`IMEC_DW-1:0] lo;
        begin
            join_halves = {hi, lo};
        end
    endfunction

    // request 0 has no source; its position is dropped wherever it could
    // reach the core, so stale bits written by software stay harmless
    function [`IMEC_DW-1:0] drop_req0;
        input [`IMEC_DW-1:0] v;
        begin
            drop_req0 = v & `IMEC_LOW_USED_MASK;
        end
    endfunction

    reg  [`IMEC_DW-1:0]   irq_enable_low_r;
    reg  [`IMEC_DW-1:0]   irq_enable_high_r;
    reg  [`IMEC_NREQ-1:0] pending_r;
    reg  [`IMEC_NREQ-1:0] irq_prev_r;
    reg  [`IMEC_NREQ-1:0] pending_nxt;
    reg  [`IMEC_NREQ-1:0] clr_vec;
    reg  [`IMEC_DW-1:0]   clr_low_vec;
    reg  [`IMEC_DW-1:0]   clr_high_vec;
    reg  [`IMEC_DW-1:0]   rdata_nxt;
    reg  [`IMEC_NREQ-1:0] masked_nxt;
    reg                   irq_nxt;
    wire [`IMEC_NREQ-1:0] enables;
    wire [`IMEC_NREQ-1:0] rise;
    wire [`IMEC_NREQ-1:0] status_vis;
    wire [`IMEC_NREQ-1:0] edge_keep;
    wire [`IMEC_NREQ-1:0] level_follow;
    wire                  wr_en_low;
    wire                  wr_en_high;
    wire                  wr_clr_low;
    wire                  wr_clr_high;

    // write decode: one strobe per writable register
    assign wr_en_low   = wr && addr_hit(addr, `IMEC_OFF_EN_LOW);
    assign wr_en_high  = wr && addr_hit(addr, `IMEC_OFF_EN_HIGH);
    assign wr_clr_low  = wr && addr_hit(addr, `IMEC_OFF_CLR_LOW);
    assign wr_clr_high = wr && addr_hit(addr, `IMEC_OFF_CLR_HIGH);

    // rising edge against the previous sample; the previous sample resets
    // low, so a line already high at release counts as one edge
    assign rise = irq_in & ~irq_prev_r;

    // status as software and the mask see it; request 0 never shows
    assign status_vis = join_halves(hi_half(pending_r),
                                    drop_req0(lo_half(pending_r)));

    // enable bit 0 is stored and reads back but never gates anything
    assign enables = join_halves(irq_enable_high_r,
                                 drop_req0(irq_enable_low_r));

    // clear vectors: a one clears, a zero leaves the latch alone
    always @* begin
        clr_low_vec  = `IMEC_ZERO16;
        clr_high_vec = `IMEC_ZERO16;
        if (wr_clr_low) begin
            // bit 0 is reserved in the low clear register
            clr_low_vec = drop_req0(wdata);
        end
        if (wr_clr_high) begin
            clr_high_vec = wdata;
        end
        clr_vec = join_halves(clr_high_vec, clr_low_vec);
    end

    // edge requests latch; a new edge in the same cycle as a clear wins,
    // so an event arriving while software clears is never lost
    assign edge_keep = edge_mode & ((pending_r & ~clr_vec) | rise);

    // level requests follow the line; a clear write cannot touch them
    assign level_follow = ~edge_mode & irq_in;

    always @* begin
        pending_nxt = edge_keep | level_follow;
    end

    // masked request: pending and enabled, both halves at once
    always @* begin
        masked_nxt = status_vis & enables;
        irq_nxt    = |masked_nxt;
    end

    // read mux; status registers are read-only views of the latches
    always @* begin
        rdata_nxt = `IMEC_ZERO16;
        case (addr)
            `IMEC_OFF_STAT_LOW: begin
                rdata_nxt = lo_half(status_vis);
            end
            `IMEC_OFF_STAT_HIGH: begin
                rdata_nxt = hi_half(status_vis);
            end
            `IMEC_OFF_EN_LOW: begin
                rdata_nxt = irq_enable_low_r;
            end
            `IMEC_OFF_EN_HIGH: begin
                rdata_nxt = irq_enable_high_r;
            end
            `IMEC_OFF_CLR_LOW: begin
                rdata_nxt = `IMEC_CLR_READ;
            end
            `IMEC_OFF_CLR_HIGH: begin
                rdata_nxt = `IMEC_CLR_READ;
            end
            default: begin
                rdata_nxt = `IMEC_ZERO16;
            end
        endcase
    end

    // previous sample of every request line, for edge detection
    always @(posedge clock) begin
        if (!rstn) begin
            irq_prev_r <= `IMEC_ZERO32;
        end else begin
            irq_prev_r <= irq_in;
        end
    end

    // pending latches of both halves
    always @(posedge clock) begin
        if (!rstn) begin
            pending_r <= join_halves(`IMEC_RST_STAT, `IMEC_RST_STAT);
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // low enable register, requests 15 down to 0
    always @(posedge clock) begin
        if (!rstn) begin
            irq_enable_low_r <= `IMEC_RST_EN;
        end else if (wr_en_low) begin
            irq_enable_low_r <= wdata;
        end
    end

    // high enable register, requests 31 down to 16
    always @(posedge clock) begin
        if (!rstn) begin
            irq_enable_high_r <= `IMEC_RST_EN;
        end else if (wr_en_high) begin
            irq_enable_high_r <= wdata;
        end
    end

    // read data stand for one cycle only and are zero otherwise, so a
    // master that samples late sees zero rather than a stale word
    always @(posedge clock) begin
        if (!rstn) begin
            rdata <= `IMEC_ZERO16;
        end else if (rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= `IMEC_ZERO16;
        end
    end

    // registered outputs: one cycle after the status, no glitches
    always @(posedge clock) begin
        if (!rstn) begin
            masked_req <= `IMEC_ZERO32;
            irq_out    <= 1'b0;
        end else begin
            masked_req <= masked_nxt;
            irq_out    <= irq_nxt;
        end
    end

endmodule // imec_unit

// ==== sim/imec_core.sv ====
/* request source of the core side; assumes tb sets fire */
`timescale 1ns/1ns
module imec_core(input wire clock, input wire [31:0] fire, output reg [31:0] irq_in);
    initial irq_in = 32'h00000000;
    // lines move only on the edge, never mid-cycle
    always @(posedge clock) irq_in <= fire;
endmodule // imec_core

// ==== sim/imec_props.sv ====
/* unit port checker; assumes bind from tb */
`timescale 1ns/1ns
module imec_props(input wire clock, input wire rstn, input wire [23:0] addr,
    input wire [15:0] wdata, input wire wr, input wire rd, input wire [15:0] rdata,
    input wire [31:0] irq_in, input wire [31:0] edge_mode,
    input wire [31:0] masked_req, input wire irq_out);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_out_is_or: assert property (irq_out == |masked_req) else $error("irq");
    a_bit0_off: assert property (!masked_req[0]) else $error("bit0");
    a_clr_ones: assert property (rd && (addr == 24'h00fe12 || addr == 24'h00fe14)
        |=> rdata == 16'hffff) else $error("clr read");
    a_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("idle");
    a_level_src: assert property ((masked_req & ~edge_mode & ~$past(irq_in, 2)) == 0)
        else $error("level src");
    a_level_keep: assert property (!$past(wr) && !$past(wr, 2) |-> (~edge_mode
        & $past(irq_in, 2) & $past(masked_req) & ~masked_req) == 0) else $error("lvl");
    a_clr_low: assert property (wr && addr == 24'h00fe12 && wdata == 16'hfffe
        && $stable(irq_in) |-> ##2 (masked_req[15:1] & edge_mode[15:1]) == 15'h0000)
        else $error("clr low");
    a_clr_high: assert property (wr && addr == 24'h00fe14 && wdata == 16'hffff
        && $stable(irq_in) |-> ##2 (masked_req[31:16] & edge_mode[31:16]) == 16'h0000)
        else $error("clr high");
    c_irq: cover property (irq_out);
    c_clr: cover property (wr && addr == 24'h00fe12);
    c_rd: cover property (rd && addr == 24'h00fe14);
endmodule // imec_props

// ==== sim/tb.sv ====
/* top bench: core model, unit, checker; assumes imec_unit, imec_props */
`timescale 1ns/1ns
module tb;
    reg clock = 0, rstn = 0, wr = 0, rd = 0;
    reg [23:0] addr = 0;
    reg [15:0] wdata = 0;
    reg [31:0] fire = 0, edge_mode = 32'hfffbfffb;
    wire [15:0] rdata;
    wire [31:0] irq_in, masked_req;
    wire irq_out;
    integer n_mismatch = 0, tests_run = 0;
    always #4 clock = ~clock;
    imec_core core_u(.clock(clock), .fire(fire), .irq_in(irq_in));
    imec_unit dut_u(.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq_in(irq_in), .edge_mode(edge_mode),
        .masked_req(masked_req), .irq_out(irq_out));
    task chk(input [31:0] s, input [31:0] e); begin
        tests_run = tests_run + 1;
        if (s !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h want %h", $time, s, e);
        end
    end endtask
    task w(input [23:0] a, input [15:0] d); begin
        @(posedge clock); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock); wr <= 1'b0;
    end endtask
    task r(input [23:0] a, input [31:0] e); begin
        @(posedge clock); addr <= a; rd <= 1'b1;
        @(posedge clock); rd <= 1'b0; #1 chk(rdata, e);
    end endtask
    task settle; begin repeat (4) @(posedge clock); #1; end endtask
    task results; begin
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        r(24'h00fe0e, 0);
        r(24'h00fe10, 0);
        w(24'h00fe14, 16'h0000); r(24'h00fe14, 32'hffff);
        w(24'h00fe0e, 16'hffff); w(24'h00fe10, 16'hffff); r(24'h00fe0e, 32'hffff);
        @(posedge clock); fire <= 32'hffffffff;
        settle; chk(masked_req, 32'hfffffffe);
        r(24'h00fe0a, 32'hfffe);
        r(24'h000000, 0);
        w(24'h00fe12, 16'hfffe); w(24'h00fe14, 16'hffff);
        settle; chk(masked_req, 32'h00040004);
        w(24'h00fe0e, 16'h0000); settle; chk(masked_req, 32'h00040000);
        w(24'h00fe10, 16'hfffb); settle; chk(irq_out, 32'h0);
        results;
    end
endmodule // tb
bind imec_unit imec_props chk_u(.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_in(irq_in), .edge_mode(edge_mode),
    .masked_req(masked_req), .irq_out(irq_out));
